// File: common/irq_regs_consts.vh
// Constants for the top-level interrupt enable and pending register block.
// Assumes an AXI4-Lite slave with 32-bit data and one aligned word per register.
`ifndef IRQ_REGS_CONSTS_VH
`define IRQ_REGS_CONSTS_VH

`define ADDR_W            32
`define DATA_W            32
`define SRC_W             17
`define OFS_ENABLE_SET    32'hE000E100
`define OFS_ENABLE_CLEAR  32'hE000E180
`define OFS_PENDING_SET   32'hE000E200
`define OFS_PENDING_CLEAR 32'hE000E280
`define OFS_IRQ_STATUS    32'hE000E400
`define OFS_IRQ_MASK      32'hE000E404
`define IMPL_MASK         17'h1D7BC
`define RESET_VAL         17'h00000
`define BIT_DEBUG         16
`define BIT_LINE_D        15
`define BIT_LINE_C        14
`define BIT_LINE_A        12
`define BIT_RADIO_RX      10
`define BIT_RADIO_TX      9
`define BIT_RADIO_TMR     8
`define BIT_SECURITY      7
`define BIT_SERIAL1       5
`define BIT_SLEEP_TMR     4
`define BIT_BASEBAND      3
`define BIT_MGMT          2
`define EVT_W             2
`define EVT_PEND_RISE     0
`define EVT_ENABLED_PEND  1
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`define ZERO_HI           15'h0000

`endif

// File: core/irq_src_bit.v
// One interrupt source: its enable and pending flip-flops.
// Assumes one-cycle write strobes from the register slave.
`timescale 1ns/100ps
`include "irq_regs_consts.vh"

module irq_src_bit #(
  parameter IMPL = 1'b1
) (
  input  wire sys_clk,    // System clock.
  input  wire rstn,       // Synchronous reset, active low.
  input  wire en_set,     // Write one to set enable.
  input  wire en_clr,     // Write one to clear enable.
  input  wire pend_set,   // Write one to set pending.
  input  wire pend_clr,   // Write one to clear pending.
  input  wire src_event,  // Hardware request from the source.
  output reg  enable_q,   // Enable state.
  output reg  pending_q   // Pending state.
);

  always @(posedge sys_clk) begin
    if (!rstn || !IMPL) begin
      enable_q  <= 1'b0; // see [R4] [R11]
      pending_q <= 1'b0;
    end else begin
      if (en_set)
        enable_q <= 1'b1; // see [R1]
      else if (en_clr)
        enable_q <= 1'b0; // see [R2]
      // A source event or a set write wins over a clear write in the same cycle.
      if (pend_set || src_event)
        pending_q <= 1'b1; // see [R3]
      else if (pend_clr)
        pending_q <= 1'b0; // see [R10]
    end
  end

endmodule // irq_src_bit

// File: core/top_level_irq_enable_pend_regs.v
// Top-level interrupt enable and pending registers behind an AXI4-Lite slave.
// Assumes a single master, one write and one read outstanding at a time.
// Overview of operation
// [R1] Writing one to a set-enable bit enables that source; zeros change nothing.
// [R2] Writing one to a clear-enable bit disables that source; zeros change nothing.
// [R3] Writing one to a set-pending bit pends that interrupt; zeros change nothing.
// [R4] Reset clears every enable and pending bit; all registers read zero.
// [R5] Debug is bit 16, line D bit 15, line C bit 14.
// [R6] Line A is bit 12, radio receive bit 10.
// [R7] Radio transmit is bit 9, radio timer bit 8.
// [R8] Security is bit 7, serial controller one bit 5, sleep timer bit 4.
// [R9] Baseband is bit 3, management bit 2.
// [R10] Writing one to a clear-pending bit unpends that interrupt; zeros do nothing.
// [R11] Reserved bits and bits 31 to 17 read zero and ignore writes.
// [R12] Both enable registers read enable state; set-pending reads pending state.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "irq_regs_consts.vh"

module top_level_irq_enable_pend_regs (
  input  wire                 sys_clk,       // System clock, 250 MHz.
  input  wire                 rstn,          // Synchronous reset, active low.
  input  wire                 debug_req,     // Debug source request pulse.
  input  wire                 line_d_req,    // External line D request.
  input  wire                 line_c_req,    // External line C request.
  input  wire                 line_a_req,    // External line A request.
  input  wire                 radio_rx_req,  // Radio receive request.
  input  wire                 radio_tx_req,  // Radio transmit request.
  input  wire                 radio_tmr_req, // Radio timer request.
  input  wire                 security_req,  // Security accelerator request.
  input  wire                 serial1_req,   // Serial controller one request.
  input  wire                 sleep_tmr_req, // Sleep timer request.
  input  wire                 baseband_req,  // Baseband request.
  input  wire                 mgmt_req,      // Management request.
  output wire [`SRC_W-1:0]    enable_out,    // Enable state per source.
  output wire [`SRC_W-1:0]    pending_out,   // Pending state per source.
  output wire                 irq,           // Level interrupt output.
  input  wire [`ADDR_W-1:0]   s_axi_awaddr,  // Write address.
  input  wire                 s_axi_awvalid, // Write address valid.
  output wire                 s_axi_awready, // Write address ready.
  input  wire [`DATA_W-1:0]   s_axi_wdata,   // Write data.
  input  wire [3:0]           s_axi_wstrb,   // Write byte strobes.
  input  wire                 s_axi_wvalid,  // Write data valid.
  output wire                 s_axi_wready,  // Write data ready.
  output reg  [1:0]           s_axi_bresp,   // Write response.
  output reg                  s_axi_bvalid,  // Write response valid.
  input  wire                 s_axi_bready,  // Write response ready.
  input  wire [`ADDR_W-1:0]   s_axi_araddr,  // Read address.
  input  wire                 s_axi_arvalid, // Read address valid.
  output wire                 s_axi_arready, // Read address ready.
  output reg  [`DATA_W-1:0]   s_axi_rdata,   // Read data.
  output reg  [1:0]           s_axi_rresp,   // Read response.
  output reg                  s_axi_rvalid,  // Read data valid.
  input  wire                 s_axi_rready   // Read data ready.
);

  reg  [`ADDR_W-1:0] awaddr_q;
  reg                aw_held_q;
  reg  [`DATA_W-1:0] wdata_q;
  reg  [3:0]         wstrb_q;
  reg                w_held_q;
  reg  [`EVT_W-1:0]  status_q;
  reg  [`EVT_W-1:0]  status_d;
  reg  [`EVT_W-1:0]  mask_q;
  reg  [`SRC_W-1:0]  pend_prev_q;
  wire [`SRC_W-1:0]  src_req;
  wire [`SRC_W-1:0]  wbits;
  wire [`SRC_W-1:0]  en_q;
  wire [`SRC_W-1:0]  pd_q;
  wire               do_write;
  wire               hit_es;
  wire               hit_ec;
  wire               hit_ps;
  wire               hit_pc;
  wire               hit_st;
  wire               hit_mk;
  wire [`EVT_W-1:0]  evt;

  // Source requests placed at their documented bit positions.
  assign src_req[`BIT_DEBUG]     = debug_req;     // see [R5]
  assign src_req[`BIT_LINE_D]    = line_d_req;    // see [R5]
  assign src_req[`BIT_LINE_C]    = line_c_req;    // see [R5]
  assign src_req[13]             = 1'b0;          // see [R11]
  assign src_req[`BIT_LINE_A]    = line_a_req;    // see [R6]
  assign src_req[11]             = 1'b0;          // see [R11]
  assign src_req[`BIT_RADIO_RX]  = radio_rx_req;  // see [R6]
  assign src_req[`BIT_RADIO_TX]  = radio_tx_req;  // see [R7]
  assign src_req[`BIT_RADIO_TMR] = radio_tmr_req; // see [R7]
  assign src_req[`BIT_SECURITY]  = security_req;  // see [R8]
  assign src_req[6]              = 1'b0;          // see [R11]
  assign src_req[`BIT_SERIAL1]   = serial1_req;   // see [R8]
  assign src_req[`BIT_SLEEP_TMR] = sleep_tmr_req; // see [R8]
  assign src_req[`BIT_BASEBAND]  = baseband_req;  // see [R9]
  assign src_req[`BIT_MGMT]      = mgmt_req;      // see [R9]
  assign src_req[1:0]            = 2'b00;         // see [R11]

  // Write channel: address and data accepted in either order, held until the response.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 32'h00000000;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hit_es || hit_ec || hit_ps || hit_pc || hit_st || hit_mk) ?
                        `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign hit_es = (awaddr_q == `OFS_ENABLE_SET);
  assign hit_ec = (awaddr_q == `OFS_ENABLE_CLEAR);
  assign hit_ps = (awaddr_q == `OFS_PENDING_SET);
  assign hit_pc = (awaddr_q == `OFS_PENDING_CLEAR);
  assign hit_st = (awaddr_q == `OFS_IRQ_STATUS);
  assign hit_mk = (awaddr_q == `OFS_IRQ_MASK);

  // Only bytes 0 to 2 carry source bits; each bit follows its lane strobe.
  assign wbits = wdata_q[`SRC_W-1:0] & `IMPL_MASK &
                 {wstrb_q[2], {8{wstrb_q[1]}}, {8{wstrb_q[0]}}} &
                 {`SRC_W{do_write}}; // see [R11]

  // One flag per bit position, so each source flop sees a single implemented bit.
  localparam [`SRC_W-1:0] IMPL_BITS = `IMPL_MASK;

  genvar i;
  generate
    for (i = 0; i < `SRC_W; i = i + 1) begin : g_src
      irq_src_bit #(
        .IMPL (IMPL_BITS[i])
      ) u_bit (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .en_set    (wbits[i] && hit_es),  // see [R1]
        .en_clr    (wbits[i] && hit_ec),  // see [R2]
        .pend_set  (wbits[i] && hit_ps),  // see [R3]
        .pend_clr  (wbits[i] && hit_pc),  // see [R10]
        .src_event (src_req[i]),
        .enable_q  (en_q[i]),
        .pending_q (pd_q[i])
      );
    end
  endgenerate

  assign enable_out  = en_q;
  assign pending_out = pd_q;

  // Events: a pending bit newly rising, and any pending bit that is enabled.
  assign evt[`EVT_PEND_RISE]    = |(pd_q & ~pend_prev_q);
  assign evt[`EVT_ENABLED_PEND] = |(pd_q & en_q);

  always @* begin
    status_d = status_q;
    if (do_write && hit_st && wstrb_q[0])
      status_d = status_q & ~wdata_q[`EVT_W-1:0];
    // A new event in the clearing cycle keeps its bit set.
    status_d = status_d | evt;
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      status_q    <= 2'b00;
      mask_q      <= 2'b00;
      pend_prev_q <= `RESET_VAL;
    end else begin
      status_q    <= status_d;
      pend_prev_q <= pd_q;
      if (do_write && hit_mk && wstrb_q[0])
        mask_q <= wdata_q[`EVT_W-1:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // Read channel: one read at a time, data registered.
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFS_ENABLE_SET,
        `OFS_ENABLE_CLEAR:  s_axi_rdata <= {`ZERO_HI, en_q};  // see [R12] [R11]
        `OFS_PENDING_SET:   s_axi_rdata <= {`ZERO_HI, pd_q};  // see [R12]
        `OFS_PENDING_CLEAR: s_axi_rdata <= {`ZERO_HI, pd_q};
        `OFS_IRQ_STATUS:    s_axi_rdata <= {30'h00000000, status_q};
        `OFS_IRQ_MASK:      s_axi_rdata <= {30'h00000000, mask_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // top_level_irq_enable_pend_regs

// File: bench/irq_regs_sva.sv
// Checker on the interrupt register block's top-level ports.
// Assumes the constants header is on the include path; bound after the module.
`timescale 1ns/100ps
`include "irq_regs_consts.vh"
module irq_regs_sva (
  input wire              sys_clk,       // Clock.
  input wire              rstn,          // Reset, active low.
  input wire              debug_req,     // Debug request.
  input wire [`SRC_W-1:0] enable_out,    // Enable state.
  input wire [`SRC_W-1:0] pending_out,   // Pending state.
  input wire              s_axi_awready, // Write address ready.
  input wire              s_axi_bvalid,  // Write response valid.
  input wire              s_axi_bready,  // Write response ready.
  input wire              s_axi_arvalid, // Read address valid.
  input wire              s_axi_rvalid,  // Read valid.
  input wire              s_axi_rready   // Read ready.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_reset_clears:
    assert property (disable iff (1'b0) !rstn |=> enable_out == 0 && pending_out == 0)
    else $error("state not cleared by reset");
  a_rsv_enable:
    assert property ((enable_out & ~`IMPL_MASK) == 0) else $error("reserved enable bit set");
  a_rsv_pending:
    assert property ((pending_out & ~`IMPL_MASK) == 0) else $error("reserved pending bit set");
  a_debug_pends:
    assert property (debug_req |=> pending_out[`BIT_DEBUG]) else $error("debug not pended");
  a_enable_by_write:
    assert property ($past(rstn) && !$stable(enable_out) |-> $rose(s_axi_bvalid))
    else $error("enable changed without a write");
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  a_read_answer:
    assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read late");
  a_busy_refuses:
    assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken while busy");
endmodule // irq_regs_sva
bind top_level_irq_enable_pend_regs irq_regs_sva u_sva (.*);

// File: bench/cpu_bus_model.sv
// Processor-side model: an AXI4-Lite master issuing one register access at a time.
// Assumes the slave answers; the bench watchdog ends any hang.
`timescale 1ns/100ps
module cpu_bus_model (
  input  wire        sys_clk,       // Clock.
  input  wire        s_axi_awready, // Write address ready.
  input  wire        s_axi_wready,  // Write data ready.
  input  wire        s_axi_bvalid,  // Write response valid.
  input  wire [1:0]  s_axi_bresp,   // Write response.
  input  wire        s_axi_arready, // Read address ready.
  input  wire        s_axi_rvalid,  // Read valid.
  input  wire [31:0] s_axi_rdata,   // Read data.
  input  wire [1:0]  s_axi_rresp,   // Read response.
  output reg  [31:0] s_axi_awaddr,  // Write address.
  output reg         s_axi_awvalid, // Write address valid.
  output reg  [31:0] s_axi_wdata,   // Write data.
  output reg         s_axi_wvalid,  // Write data valid.
  output reg         s_axi_bready,  // Write response ready.
  output reg  [31:0] s_axi_araddr,  // Read address.
  output reg         s_axi_arvalid, // Read address valid.
  output reg         s_axi_rready   // Read ready.
);
  reg done;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 66'h0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 35'h0;
  end
  // Handshakes are judged at the rising edge on the values that stand before it.
  task wr(input [31:0] a, input [31:0] d, output [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        done = 1'b1;
        r = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [31:0] a, output [31:0] d, output [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule // cpu_bus_model

// File: bench/testbench.sv
// Self-checking bench for the interrupt enable and pending register block.
// Assumes the bus model and the checker are compiled ahead of it.
`timescale 1ns/100ps
`include "irq_regs_consts.vh"
module testbench;
  reg         sys_clk, rstn;
  reg  [16:0] ev;
  wire [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  wire [16:0] enable_out, pending_out;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        irq, s_axi_awready, s_axi_awvalid, s_axi_wready, s_axi_wvalid, s_axi_bvalid;
  wire        s_axi_bready, s_axi_arready, s_axi_arvalid, s_axi_rvalid, s_axi_rready;
  wire [3:0]  s_axi_wstrb = 4'hF;
  integer     fail_count, cmp_count, i;
  reg  [31:0] rv;
  reg  [1:0]  rs;
  localparam [31:0] IMPL = {`ZERO_HI, `IMPL_MASK};
  cpu_bus_model u_cpu (.*);
  top_level_irq_enable_pend_regs u_dut (.*, .debug_req(ev[16]), .line_d_req(ev[15]),
    .line_c_req(ev[14]), .line_a_req(ev[12]), .radio_rx_req(ev[10]), .radio_tx_req(ev[9]),
    .radio_tmr_req(ev[8]), .security_req(ev[7]), .serial1_req(ev[5]),
    .sleep_tmr_req(ev[4]), .baseband_req(ev[3]), .mgmt_req(ev[2]));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task w(input [31:0] a, input [31:0] d);
    u_cpu.wr(a, d, rs);
    chk("bresp", `RESP_OKAY, {30'h0, rs});
    @(negedge sys_clk);
  endtask
  task rc(input string nm, input [31:0] a, input [31:0] e);
    u_cpu.rd(a, rv, rs);
    chk(nm, e, rv);
  endtask
  task t_reset;
    chk("enable_out", 0, enable_out);
    rc("enable set", `OFS_ENABLE_SET, 0);
    rc("enable clear", `OFS_ENABLE_CLEAR, 0);
    rc("pending set", `OFS_PENDING_SET, 0);
  endtask
  task t_enable;
    w(`OFS_ENABLE_SET, 32'hFFFFFFFF);
    rc("enable clear", `OFS_ENABLE_CLEAR, IMPL);
    w(`OFS_ENABLE_CLEAR, 32'h00008004);
    w(`OFS_ENABLE_SET, 32'h0);
    rc("enable set", `OFS_ENABLE_SET, IMPL & ~32'h8004);
    w(`OFS_ENABLE_CLEAR, 32'hFFFFFFFF);
    chk("enable_out", 0, enable_out);
  endtask
  task t_map;
    for (i = 0; i < 17; i = i + 1) begin
      w(`OFS_PENDING_SET, 32'h1 << i);
      chk("pending_out", IMPL & (32'h1 << i), pending_out);
      w(`OFS_PENDING_CLEAR, 32'h0);
      chk("pending kept", IMPL & (32'h1 << i), pending_out);
      w(`OFS_PENDING_CLEAR, 32'h1 << i);
      if (IMPL[i]) begin
        @(posedge sys_clk);
        ev <= 17'h1 << i;
        @(posedge sys_clk);
        ev <= 17'h0;
        rc("event pending", `OFS_PENDING_SET, 32'h1 << i);
        w(`OFS_PENDING_CLEAR, 32'h1 << i);
      end
    end
    chk("pending_out", 0, pending_out);
  endtask
  task t_irq;
    w(`OFS_IRQ_MASK, 32'h1);
    w(`OFS_PENDING_SET, 32'h4);
    rc("status", `OFS_IRQ_STATUS, 32'h1);
    chk("irq", 1, irq);
    w(`OFS_IRQ_MASK, 32'h0);
    chk("irq masked", 0, irq);
    w(`OFS_IRQ_MASK, 32'h1);
    w(`OFS_PENDING_CLEAR, 32'h4);
    w(`OFS_IRQ_STATUS, 32'h3);
    chk("irq cleared", 0, irq);
  endtask
  task t_bad;
    u_cpu.wr(32'hE000E300, 32'hFFFFFFFF, rs);
    chk("bresp", `RESP_SLVERR, {30'h0, rs});
    u_cpu.rd(32'hE000E300, rv, rs);
    chk("rresp", `RESP_SLVERR, {30'h0, rs});
    chk("rdata", 0, rv);
    chk("enable_out", 0, enable_out);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    rstn = 1'b0;
    ev = 17'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_enable;
    t_map;
    t_irq;
    t_bad;
    finish_test;
  end
  initial begin
    #200000;
    fail_count = fail_count + 1;
    finish_test;
  end
endmodule // testbench
